// ==== verilog/pkt_mem_map.vh ====
// register offsets, field positions, reset values and sizes of the memory command unit
`ifndef PKT_MEM_MAP_VH
`define PKT_MEM_MAP_VH
`define OFF_MEMORY_COMMAND 3'h0
`define OFF_PACKET_SELECT 3'h2
`define OFF_ALLOC_RESULT 3'h3
`define OFF_QUEUE_PORTS 3'h4
`define OFF_CONTROL 3'h5
`define CMD_LSB 5
`define CMD_MSB 7
`define SIZE_LSB 0
`define SIZE_MSB 2
`define BUSY_BIT 0
`define FAILED_BIT 7
`define CTL_ACCEPT_BAD_CRC 0
`define CTL_AUTO_RELEASE 1
`define CTL_TX_ENABLE 2
`define CMD_NOOP 3'h0
`define CMD_ALLOCATE 3'h1
`define CMD_RESET_MGR 3'h2
`define CMD_RX_POP 3'h3
`define CMD_RX_POP_RELEASE 3'h4
`define CMD_RELEASE_PKT 3'h5
`define CMD_TX_ENQUEUE 3'h6
`define CMD_TX_RESET 3'h7
`define NUM_PACKETS 64
`define PKT_W 6
`define QPTR_W 7
`define RELEASE_CYCLES 4'h4
`define PACKET_SELECT_RESET 8'h00
`endif

// ==== verilog/pkt_queue.v ====
// packet number queue of fixed depth with flush
`timescale 1ns/1ps
`include "pkt_mem_map.vh"
module pkt_queue (
  input wire clk,
  input wire reset_n,
  input wire flush,
  input wire push,
  input wire [`PKT_W-1:0] push_pkt,
  input wire pop,
  output wire [`PKT_W-1:0] head_pkt,
  output wire empty,
  output wire full
);
  reg [`PKT_W-1:0] mem [0:`NUM_PACKETS-1];
  reg [`QPTR_W-1:0] wr_r;
  reg [`QPTR_W-1:0] rd_r;
  wire do_push;
  wire do_pop;
  assign empty = (wr_r == rd_r);
  assign full = (wr_r[`QPTR_W-1] != rd_r[`QPTR_W-1]) &&
    (wr_r[`QPTR_W-2:0] == rd_r[`QPTR_W-2:0]);
  assign head_pkt = mem[rd_r[`QPTR_W-2:0]];
  // pushes into a full queue are dropped rather than corrupting the head
  assign do_push = push && !full;
  assign do_pop = pop && !empty;
  always @(posedge clk) begin
    if (do_push) begin
      mem[wr_r[`QPTR_W-2:0]] <= push_pkt;
    end
  end
  always @(posedge clk) begin
    if (!reset_n || flush) begin
      wr_r <= {`QPTR_W{1'b0}};
      rd_r <= {`QPTR_W{1'b0}};
    end else begin
      if (do_push) begin
        wr_r <= wr_r + 1'b1;
      end
      if (do_pop) begin
        rd_r <= rd_r + 1'b1;
      end
    end
  end
endmodule // pkt_queue

// ==== verilog/page_pool.v ====
// ownership table of packet numbers: allocate lowest free, release by number
`timescale 1ns/1ps
`include "pkt_mem_map.vh"
module page_pool (
  input wire clk,
  input wire reset_n,
  input wire free_all,
  input wire alloc_req,
  output reg alloc_ok,
  output reg [`PKT_W-1:0] alloc_pkt,
  input wire rel_req,
  input wire [`PKT_W-1:0] rel_pkt,
  input wire rx_alloc_req,
  output wire [`PKT_W-1:0] rx_alloc_pkt,
  output wire rx_alloc_ok
);
  reg [`NUM_PACKETS-1:0] used_r;
  reg [`NUM_PACKETS-1:0] used_nxt;
  reg [`PKT_W-1:0] first_free;
  reg any_free;
  integer i;
  always @* begin
    first_free = {`PKT_W{1'b0}};
    any_free = 1'b0;
    for (i = `NUM_PACKETS-1; i >= 0; i = i - 1) begin
      if (!used_r[i]) begin
        first_free = i[`PKT_W-1:0];
        any_free = 1'b1;
      end
    end
  end
  // host allocation has priority; receive waits a cycle when both ask
  assign rx_alloc_ok = any_free && !alloc_req;
  assign rx_alloc_pkt = first_free;
  always @* begin
    used_nxt = used_r;
    if (rel_req) begin
      used_nxt[rel_pkt] = 1'b0;
    end
    if ((alloc_req || rx_alloc_req) && any_free) begin
      used_nxt[first_free] = 1'b1;
    end
  end
  always @(posedge clk) begin
    if (!reset_n || free_all) begin
      used_r <= {`NUM_PACKETS{1'b0}};
      alloc_ok <= 1'b0;
      alloc_pkt <= {`PKT_W{1'b0}};
    end else begin
      used_r <= used_nxt;
      alloc_ok <= alloc_req && any_free;
      if (alloc_req && any_free) begin
        alloc_pkt <= first_free;
      end
    end
  end
endmodule // page_pool

// ==== verilog/packet_memory_command_unit.v ====
// command decoder and bookkeeping of the packet buffer memory manager
// Function
// (RULE1) command 000 does nothing
// (RULE2) command 001 allocates transmit memory and posts a result at once; this device posts it three cycles after the write
// (RULE3) size bits request (n+1)*256 bytes; this device ignores them
// (RULE4) command 010 frees all memory, clears events, resets queue pointers
// (RULE5) command 011 drops receive queue head and shows the next
// (RULE6) command 100 does as 011 and frees the head packet's pages
// (RULE7) command 101 frees pages of the packet in the packet select
// (RULE8) command 110 pushes the packet select number into transmit queue
// (RULE9) command 111 empties both transmit queues, freeing no memory
// (RULE10) host resets transmit queues only with transmitter disabled
// (RULE11) host waits for allocation completion before the next allocate
// (RULE12) host waits for busy low before the next release command
// (RULE13) host releases only allocated packets, never queued ones
// (RULE14) command register read shows busy at bit 0 during release
// (RULE15) busy and allocation failed set at end of command write
// (RULE16) packet select cleared by reset and manager reset
// (RULE17) auto release frees good packets, skips completion queue
// (RULE18) auto release interrupts only on drain or fatal error
// (RULE19) fatal error clears transmit enable, leaves packet allocated
// (RULE20) bad crc frames kept if accepted, else freed silently
// (RULE21) failed reads zero after success, stays set until satisfied
// (RULE22) command taken from low byte writes only
`timescale 1ns/1ps
`include "pkt_mem_map.vh"
module packet_memory_command_unit (
  input wire clk,
  input wire reset_n,
  input wire [2:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire [1:0] reg_byte_en,
  input wire reg_write,
  input wire reg_read,
  output reg [15:0] reg_rdata,
  input wire tx_req,
  output wire tx_busy,
  output wire [`PKT_W-1:0] tx_pkt,
  input wire tx_done,
  input wire tx_success,
  input wire rx_frame_start,
  output wire rx_frame_ok,
  output wire [`PKT_W-1:0] rx_frame_pkt,
  input wire rx_frame_end,
  input wire rx_crc_bad,
  output reg allocation_done_event,
  output reg tx_complete_event,
  output reg tx_empty_event,
  output reg rx_event,
  input wire [1:0] event_ack,
  output wire [7:0] tx_area_packet_select
);
  localparam ST_IDLE = 3'b001;
  localparam ST_RELEASE = 3'b010;
  localparam ST_SEND = 3'b100;
  reg [7:0] tx_area_packet_select_r;
  reg alloc_pending_r;
  reg alloc_failed_r;
  reg [`PKT_W-1:0] alloc_pkt_r;
  reg busy_r;
  reg [3:0] busy_cnt_r;
  reg accept_bad_crc_r;
  reg auto_release_r;
  reg transmit_enable_flag_r;
  reg [2:0] tx_state_r;
  reg [`PKT_W-1:0] tx_cur_r;
  reg [`PKT_W-1:0] rx_cur_r;
  reg rx_active_r;
  reg rel_req;
  reg [`PKT_W-1:0] rel_pkt;
  wire low_wr;
  wire cmd_wr;
  wire [2:0] cmd;
  wire [2:0] allocation_size_code;
  wire mgr_reset;
  wire txq_flush;
  wire pool_ok;
  wire [`PKT_W-1:0] pool_pkt;
  wire [`PKT_W-1:0] rx_alloc_pkt;
  wire rx_head_empty;
  wire [`PKT_W-1:0] rx_head;
  wire txq_empty;
  wire [`PKT_W-1:0] txq_head;
  wire done_empty;
  wire [`PKT_W-1:0] done_head;
  wire txq_full;
  wire rxq_full;
  wire done_full;
  wire rx_keep;
  wire rx_drop;
  wire txq_pop;
  wire done_push;
  wire good_release;

  function [7:0] pkt_byte;
    input empty_flag;
    input [`PKT_W-1:0] pkt;
    begin
      pkt_byte = {empty_flag, 1'b0, pkt};
    end
  endfunction

  // a high byte write alone never starts a command
  assign low_wr = reg_write && reg_byte_en[0]; // RULE22
  assign cmd_wr = low_wr && (reg_addr == `OFF_MEMORY_COMMAND);
  assign cmd = reg_wdata[`CMD_MSB:`CMD_LSB];
  // size code kept visible for debug only; allocation is page-count blind
  assign allocation_size_code = reg_wdata[`SIZE_MSB:`SIZE_LSB]; // RULE3
  assign mgr_reset = cmd_wr && (cmd == `CMD_RESET_MGR); // RULE4
  assign txq_flush = mgr_reset || (cmd_wr && (cmd == `CMD_TX_RESET)); // RULE9
  assign tx_area_packet_select = tx_area_packet_select_r;

  // transmit sequencer
  assign tx_busy = (tx_state_r == ST_SEND);
  assign tx_pkt = tx_cur_r;
  assign txq_pop = (tx_state_r == ST_IDLE) && tx_req && !txq_empty &&
    transmit_enable_flag_r;
  assign good_release = (tx_state_r == ST_SEND) && tx_done && tx_success &&
    auto_release_r; // RULE17
  assign done_push = (tx_state_r == ST_SEND) && tx_done && !good_release;

  // receive side: keep the frame unless crc is bad and not accepted
  assign rx_keep = rx_active_r && rx_frame_end &&
    (!rx_crc_bad || accept_bad_crc_r); // RULE20
  assign rx_drop = rx_active_r && rx_frame_end && !rx_keep; // RULE20
  assign rx_frame_pkt = rx_cur_r;

  page_pool u_pool (
    .clk(clk),
    .reset_n(reset_n),
    .free_all(mgr_reset),
    // the grant ends the request, so one command takes exactly one packet
    .alloc_req(alloc_pending_r && !pool_ok),
    .alloc_ok(pool_ok),
    .alloc_pkt(pool_pkt),
    .rel_req(rel_req),
    .rel_pkt(rel_pkt),
    .rx_alloc_req(rx_frame_start && !rx_active_r && rx_frame_ok),
    .rx_alloc_pkt(rx_alloc_pkt),
    .rx_alloc_ok(rx_frame_ok)
  );

  pkt_queue u_rx_queue (
    .clk(clk),
    .reset_n(reset_n),
    .flush(mgr_reset),
    .push(rx_keep),
    .push_pkt(rx_cur_r),
    .pop(cmd_wr && ((cmd == `CMD_RX_POP) ||
      (cmd == `CMD_RX_POP_RELEASE))), // RULE5 RULE6
    .head_pkt(rx_head),
    .empty(rx_head_empty),
    .full(rxq_full)
  );

  pkt_queue u_tx_queue (
    .clk(clk),
    .reset_n(reset_n),
    .flush(txq_flush),
    .push(cmd_wr && (cmd == `CMD_TX_ENQUEUE)), // RULE8
    .push_pkt(tx_area_packet_select_r[`PKT_W-1:0]),
    .pop(txq_pop),
    .head_pkt(txq_head),
    .empty(txq_empty),
    .full(txq_full)
  );

  pkt_queue u_done_queue (
    .clk(clk),
    .reset_n(reset_n),
    .flush(txq_flush),
    .push(done_push),
    .push_pkt(tx_cur_r),
    .pop(event_ack[0] && !done_empty),
    .head_pkt(done_head),
    .empty(done_empty),
    .full(done_full)
  );

  // page release requests; a good auto-release shares the port with the
  // host release, which the host may only issue when busy is low
  always @* begin
    rel_req = 1'b0;
    rel_pkt = {`PKT_W{1'b0}};
    if (cmd_wr && (cmd == `CMD_RX_POP_RELEASE) && !rx_head_empty) begin
      rel_req = 1'b1; // RULE6
      rel_pkt = rx_head;
    end else if (cmd_wr && (cmd == `CMD_RELEASE_PKT)) begin
      rel_req = 1'b1; // RULE7
      rel_pkt = tx_area_packet_select_r[`PKT_W-1:0];
    end else if (good_release) begin
      rel_req = 1'b1; // RULE17
      rel_pkt = tx_cur_r;
    end else if (rx_drop) begin
      rel_req = 1'b1; // RULE20
      rel_pkt = rx_cur_r;
    end
  end

  // host-side registers and allocation bookkeeping
  always @(posedge clk) begin
    if (!reset_n) begin
      tx_area_packet_select_r <= `PACKET_SELECT_RESET;
      alloc_pending_r <= 1'b0;
      alloc_failed_r <= 1'b1;
      alloc_pkt_r <= {`PKT_W{1'b0}};
      busy_r <= 1'b0;
      busy_cnt_r <= 4'h0;
      accept_bad_crc_r <= 1'b0;
      auto_release_r <= 1'b0;
      allocation_done_event <= 1'b0;
    end else if (mgr_reset) begin
      tx_area_packet_select_r <= `PACKET_SELECT_RESET; // RULE16
      alloc_pending_r <= 1'b0;
      alloc_failed_r <= 1'b1; // RULE21
      busy_r <= 1'b0;
      busy_cnt_r <= 4'h0;
      allocation_done_event <= 1'b0; // RULE4
    end else begin
      if (low_wr && (reg_addr == `OFF_PACKET_SELECT)) begin
        tx_area_packet_select_r <= reg_wdata[7:0];
      end
      if (low_wr && (reg_addr == `OFF_CONTROL)) begin
        accept_bad_crc_r <= reg_wdata[`CTL_ACCEPT_BAD_CRC];
        auto_release_r <= reg_wdata[`CTL_AUTO_RELEASE];
      end
      if (cmd_wr && (cmd == `CMD_ALLOCATE)) begin
        alloc_pending_r <= 1'b1; // RULE2
        alloc_failed_r <= 1'b1; // RULE15
      end else if (pool_ok) begin
        alloc_pending_r <= 1'b0;
        alloc_failed_r <= 1'b0; // RULE21
        alloc_pkt_r <= pool_pkt; // RULE2
      end
      // set wins over the acknowledge
      if (pool_ok) begin
        allocation_done_event <= 1'b1;
      end else if (event_ack[1]) begin
        allocation_done_event <= 1'b0;
      end
      // release work takes a fixed time; busy covers it
      if (cmd_wr && ((cmd == `CMD_RX_POP_RELEASE) ||
          (cmd == `CMD_RELEASE_PKT))) begin
        busy_r <= 1'b1; // RULE15
        busy_cnt_r <= `RELEASE_CYCLES;
      end else if (busy_cnt_r != 4'h0) begin
        busy_cnt_r <= busy_cnt_r - 4'h1;
        busy_r <= (busy_cnt_r != 4'h1); // RULE14
      end
    end
  end

  // transmit sequencer and completion events
  always @(posedge clk) begin
    if (!reset_n) begin
      tx_state_r <= ST_IDLE;
      tx_cur_r <= {`PKT_W{1'b0}};
      transmit_enable_flag_r <= 1'b0;
      tx_complete_event <= 1'b0;
      tx_empty_event <= 1'b0;
    end else begin
      if (low_wr && (reg_addr == `OFF_CONTROL)) begin
        transmit_enable_flag_r <= reg_wdata[`CTL_TX_ENABLE];
      end
      case (tx_state_r)
        ST_IDLE: begin
          if (txq_pop) begin
            tx_cur_r <= txq_head;
            tx_state_r <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (tx_done) begin
            tx_state_r <= ST_RELEASE;
            if (!tx_success) begin
              transmit_enable_flag_r <= 1'b0; // RULE19
            end
          end
        end
        ST_RELEASE: begin
          tx_state_r <= ST_IDLE;
        end
        default: begin
          tx_state_r <= ST_IDLE;
        end
      endcase
      if (txq_flush) begin
        tx_state_r <= ST_IDLE; // RULE9
      end
      // with auto release only errors post completion events
      if (done_push && (!auto_release_r || !tx_success)) begin
        tx_complete_event <= 1'b1; // RULE18
      end else if (event_ack[0] || mgr_reset) begin
        tx_complete_event <= 1'b0;
      end
      if ((tx_state_r == ST_RELEASE) && txq_empty &&
          transmit_enable_flag_r) begin
        tx_empty_event <= 1'b1; // RULE18
      end else if (event_ack[0] || mgr_reset) begin
        tx_empty_event <= 1'b0;
      end
    end
  end

  // receive frame tracking
  always @(posedge clk) begin
    if (!reset_n || mgr_reset) begin
      rx_active_r <= 1'b0;
      rx_cur_r <= {`PKT_W{1'b0}};
      rx_event <= 1'b0;
    end else begin
      if (rx_frame_start && !rx_active_r && rx_frame_ok) begin
        rx_active_r <= 1'b1;
        rx_cur_r <= rx_alloc_pkt;
      end else if (rx_frame_end) begin
        rx_active_r <= 1'b0;
      end
      if (rx_keep) begin
        rx_event <= 1'b1; // RULE20
      end else if (event_ack[1]) begin
        rx_event <= 1'b0;
      end
    end
  end

  // read mux; command register returns only busy
  always @* begin
    reg_rdata = 16'h0000;
    if (reg_read) begin
      case (reg_addr)
        `OFF_MEMORY_COMMAND: reg_rdata[`BUSY_BIT] = busy_r; // RULE1 RULE14
        `OFF_PACKET_SELECT: reg_rdata[7:0] = tx_area_packet_select_r;
        `OFF_ALLOC_RESULT: begin
          reg_rdata[7:0] = {alloc_failed_r, 1'b0, alloc_pkt_r}; // RULE21
        end
        `OFF_QUEUE_PORTS: begin
          reg_rdata = {pkt_byte(rx_head_empty, rx_head),
            pkt_byte(done_empty, done_head)};
        end
        `OFF_CONTROL: begin
          reg_rdata[`CTL_ACCEPT_BAD_CRC] = accept_bad_crc_r;
          reg_rdata[`CTL_AUTO_RELEASE] = auto_release_r;
          reg_rdata[`CTL_TX_ENABLE] = transmit_enable_flag_r;
        end
        default: reg_rdata = 16'h0000;
      endcase
    end
  end
endmodule // packet_memory_command_unit

// ==== test/cmd_unit_props.sv ====
// concurrent checks on the ports of the memory command unit
`timescale 1ns/1ps
`include "pkt_mem_map.vh"
module cmd_unit_props (
  input wire clk,
  input wire reset_n,
  input wire [2:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire [1:0] reg_byte_en,
  input wire reg_write,
  input wire reg_read,
  input wire [15:0] reg_rdata,
  input wire tx_done,
  input wire tx_success,
  input wire rx_frame_end,
  input wire rx_crc_bad,
  input wire allocation_done_event,
  input wire tx_complete_event,
  input wire rx_event,
  input wire [7:0] tx_area_packet_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // control bits mirrored from host writes; hardware clearing is not tracked
  reg accept_r;
  reg auto_r;
  wire ctl_wr = reg_write && reg_byte_en[0] && reg_addr == `OFF_CONTROL;
  wire cmd_wr = reg_write && reg_byte_en[0] &&
    reg_addr == `OFF_MEMORY_COMMAND;
  wire [2:0] cmd = reg_wdata[`CMD_MSB:`CMD_LSB];
  always @(posedge clk) begin
    if (!reset_n) begin
      accept_r <= 1'b0;
      auto_r <= 1'b0;
    end else if (ctl_wr) begin
      accept_r <= reg_wdata[`CTL_ACCEPT_BAD_CRC];
      auto_r <= reg_wdata[`CTL_AUTO_RELEASE];
    end
  end
  sequence s_cmd(c);
    cmd_wr && cmd == c;
  endsequence
  sequence s_rel;
    cmd_wr && (cmd == `CMD_RELEASE_PKT || cmd == `CMD_RX_POP_RELEASE);
  endsequence
  sequence s_poll(a);
    reg_read && reg_addr == a;
  endsequence
  property p_noop;
    s_cmd(`CMD_NOOP) ##0 !allocation_done_event
      |=> !allocation_done_event [*2];
  endproperty
  a_noop: assert property (p_noop) else $error("noop changed state");
  property p_alloc;
    s_cmd(`CMD_ALLOCATE) |-> ##3 allocation_done_event;
  endproperty
  a_alloc: assert property (p_alloc) else $error("alloc not done");
  property p_failed_clr;
    s_cmd(`CMD_ALLOCATE) ##[3:8] s_poll(`OFF_ALLOC_RESULT)
      |-> !reg_rdata[`FAILED_BIT];
  endproperty
  a_failed_clr: assert property (p_failed_clr) else $error("failed set");
  property p_busy_set;
    s_rel ##2 s_poll(`OFF_MEMORY_COMMAND) |-> reg_rdata[`BUSY_BIT];
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy low");
  property p_busy_clr;
    s_rel ##8 s_poll(`OFF_MEMORY_COMMAND) |-> !reg_rdata[`BUSY_BIT];
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy stuck");
  property p_mgr;
    s_cmd(`CMD_RESET_MGR) |-> ##2 (!allocation_done_event &&
      !tx_complete_event && !rx_event &&
      tx_area_packet_select == `PACKET_SELECT_RESET);
  endproperty
  a_mgr: assert property (p_mgr) else $error("manager reset failed");
  property p_sel;
    reg_write && reg_byte_en[0] && reg_addr == `OFF_PACKET_SELECT
      |=> tx_area_packet_select == $past(reg_wdata[7:0]);
  endproperty
  a_sel: assert property (p_sel) else $error("select not written");
  property p_high;
    reg_write && reg_byte_en == 2'h2 && reg_addr == `OFF_MEMORY_COMMAND &&
      !allocation_done_event |=> !allocation_done_event [*2];
  endproperty
  a_high: assert property (p_high) else $error("high byte acted");
  property p_auto_ok;
    tx_done && tx_success && auto_r && !tx_complete_event
      |=> !tx_complete_event [*3];
  endproperty
  a_auto_ok: assert property (p_auto_ok) else $error("good tx queued");
  property p_fatal;
    tx_done && !tx_success && auto_r |-> ##[1:3] tx_complete_event;
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal not flagged");
  property p_badcrc;
    rx_frame_end && rx_crc_bad && !accept_r && !rx_event
      |=> !rx_event [*3];
  endproperty
  a_badcrc: assert property (p_badcrc) else $error("bad frame flagged");
endmodule // cmd_unit_props
bind packet_memory_command_unit cmd_unit_props props (.clk(clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_byte_en(reg_byte_en), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .tx_done(tx_done), .tx_success(tx_success),
  .rx_frame_end(rx_frame_end), .rx_crc_bad(rx_crc_bad),
  .allocation_done_event(allocation_done_event),
  .tx_complete_event(tx_complete_event), .rx_event(rx_event),
  .tx_area_packet_select(tx_area_packet_select));

// ==== test/mac_model.sv ====
// behavioural transmit and receive engines facing the unit
`timescale 1ns/1ps
`include "pkt_mem_map.vh"
module mac_model (
  input wire clk,
  input wire tx_busy,
  input wire [`PKT_W-1:0] tx_pkt,
  input wire rx_frame_ok,
  output reg tx_req,
  output reg tx_done,
  output reg tx_success,
  output reg rx_frame_start,
  output reg rx_frame_end,
  output reg rx_crc_bad
);
  reg [`PKT_W-1:0] last_pkt;
  integer i;
  initial begin
    tx_req = 1'b0;
    tx_done = 1'b0;
    tx_success = 1'b0;
    rx_frame_start = 1'b0;
    rx_frame_end = 1'b0;
    rx_crc_bad = 1'b0;
    last_pkt = 0;
  end
  // transmitter readiness; while low the unit must leave its queue alone
  task ready(input r);
    begin
      @(posedge clk);
      tx_req <= r;
    end
  endtask
  task send(input ok);
    begin
      for (i = 0; i < 200 && tx_busy !== 1'b1; i = i + 1)
        @(posedge clk);
      #1;
      last_pkt = tx_pkt;
      repeat (6) @(posedge clk);
      tx_done <= 1'b1;
      tx_success <= ok;
      @(posedge clk);
      tx_done <= 1'b0;
      // status is only meaningful beside the done pulse
      tx_success <= ~ok;
    end
  endtask
  task recv(input bad);
    begin
      for (i = 0; i < 200 && rx_frame_ok !== 1'b1; i = i + 1)
        @(posedge clk);
      @(posedge clk);
      rx_frame_start <= 1'b1;
      @(posedge clk);
      rx_frame_start <= 1'b0;
      repeat (3) @(posedge clk);
      rx_frame_end <= 1'b1;
      rx_crc_bad <= bad;
      @(posedge clk);
      rx_frame_end <= 1'b0;
      rx_crc_bad <= ~bad;
    end
  endtask
endmodule // mac_model

// ==== test/tb.sv ====
// self-checking bench for the memory command unit
`timescale 1ns/1ps
`include "pkt_mem_map.vh"
module tb;
  reg clk = 1'b0;
  reg reset_n = 1'b0;
  reg [2:0] reg_addr = 3'h0;
  reg [15:0] reg_wdata = 16'h0000;
  reg [1:0] reg_byte_en = 2'h0;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  reg [1:0] event_ack = 2'h0;
  reg [15:0] d;
  integer err_count = 0;
  integer check_count = 0;
  wire [15:0] reg_rdata;
  wire [`PKT_W-1:0] tx_pkt;
  wire [`PKT_W-1:0] rx_frame_pkt;
  wire [7:0] sel;
  wire tx_req, tx_busy, tx_done, tx_success, rx_frame_start, rx_frame_ok;
  wire rx_frame_end, rx_crc_bad, ev_alloc, ev_txc, ev_txe, ev_rx;
  wire [3:0] ev = {ev_rx, ev_txe, ev_txc, ev_alloc};
  always #2.5 clk = ~clk;
  packet_memory_command_unit uut (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_byte_en(reg_byte_en),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .tx_req(tx_req), .tx_busy(tx_busy), .tx_pkt(tx_pkt),
    .tx_done(tx_done), .tx_success(tx_success),
    .rx_frame_start(rx_frame_start), .rx_frame_ok(rx_frame_ok),
    .rx_frame_pkt(rx_frame_pkt), .rx_frame_end(rx_frame_end),
    .rx_crc_bad(rx_crc_bad), .allocation_done_event(ev_alloc),
    .tx_complete_event(ev_txc), .tx_empty_event(ev_txe), .rx_event(ev_rx),
    .event_ack(event_ack), .tx_area_packet_select(sel));
  mac_model mac (.clk(clk), .tx_busy(tx_busy), .tx_pkt(tx_pkt),
    .rx_frame_ok(rx_frame_ok), .tx_req(tx_req), .tx_done(tx_done),
    .tx_success(tx_success), .rx_frame_start(rx_frame_start),
    .rx_frame_end(rx_frame_end), .rx_crc_bad(rx_crc_bad));
  task chk(input [15:0] g, input [15:0] e, input [15:0] m);
    begin
      check_count = check_count + 1;
      if ((g & m) !== e) begin
        err_count = err_count + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g & m, e);
      end
    end
  endtask
  task wr(input [2:0] a, input [15:0] v, input [1:0] be);
    begin
      @(posedge clk);
      reg_read <= 1'b0;
      reg_addr <= a;
      reg_wdata <= v;
      reg_byte_en <= be;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
    end
  endtask
  task rd(input [2:0] a);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(negedge clk);
      d = reg_rdata;
    end
  endtask
  task ack(input [1:0] v);
    begin
      @(posedge clk);
      event_ack <= v;
      @(posedge clk);
      event_ack <= 2'h0;
    end
  endtask
  task wev(input integer b);
    integer i;
    begin
      for (i = 0; i < 200 && ev[b] !== 1'b1; i = i + 1)
        @(posedge clk);
      #1;
    end
  endtask
  // size code 7 on purpose: the unit must ignore it
  task alloc(input [5:0] p);
    begin
      wr(`OFF_MEMORY_COMMAND, 16'h0027, 2'h3);
      wev(0);
      rd(`OFF_ALLOC_RESULT);
      chk(d, {10'h000, p}, 16'h00BF);
      chk({12'h000, ev}, 16'h0001, 16'h0001);
      ack(2'h2);
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    err_count = err_count + 1;
    stop_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rd(`OFF_ALLOC_RESULT);
    chk(d, 16'h0080, 16'h0080);
    rd(`OFF_PACKET_SELECT);
    chk(d, 16'h0000, 16'h00FF);
    wr(0, 16'h0000, 2'h3);
    wr(0, 16'h2020, 2'h2);
    rd(`OFF_ALLOC_RESULT);
    chk(d, 16'h0080, 16'h0080);
    alloc(6'h00);
    alloc(6'h01);
    wr(2, 16'h0001, 2'h3);
    wr(0, 16'h00A0, 2'h3);
    rd(0);
    chk(d, 16'h0001, 16'h0001);
    repeat (5) @(posedge clk);
    rd(0);
    chk(d, 16'h0000, 16'h0001);
    alloc(6'h01);
    mac.ready(1'b1);
    wr(5, 16'h0004, 2'h3);
    wr(2, 16'h0000, 2'h3);
    wr(0, 16'h00C0, 2'h3);
    mac.send(1'b1);
    chk({10'h000, mac.last_pkt}, 16'h0000, 16'h003F);
    wev(1);
    rd(`OFF_QUEUE_PORTS);
    chk(d, 16'h0000, 16'h00BF);
    ack(2'h1);
    wr(5, 16'h0006, 2'h3);
    wr(2, 16'h0001, 2'h3);
    wr(0, 16'h00C0, 2'h3);
    mac.send(1'b1);
    wev(2);
    chk({12'h000, ev}, 16'h0004, 16'h0006);
    wr(2, 16'h0000, 2'h3);
    wr(0, 16'h00C0, 2'h3);
    mac.send(1'b0);
    wev(1);
    rd(`OFF_CONTROL);
    chk(d, 16'h0000, 16'h0004);
    rd(`OFF_QUEUE_PORTS);
    chk(d, 16'h0000, 16'h00BF);
    ack(2'h1);
    // transmitter is off here, so the queue reset is legal
    wr(0, 16'h00C0, 2'h3);
    wr(0, 16'h00E0, 2'h3);
    wr(5, 16'h0004, 2'h3);
    repeat (20) @(posedge clk);
    chk({15'h0000, tx_busy}, 16'h0000, 16'h0001);
    wr(5, 16'h0000, 2'h3);
    mac.recv(1'b0);
    wev(3);
    rd(`OFF_QUEUE_PORTS);
    chk(d, 16'h0000, 16'h8000);
    ack(2'h2);
    wr(0, 16'h0060, 2'h3);
    rd(`OFF_QUEUE_PORTS);
    chk(d, 16'h8000, 16'h8000);
    mac.recv(1'b1);
    repeat (4) @(posedge clk);
    chk({12'h000, ev}, 16'h0000, 16'h0008);
    wr(5, 16'h0001, 2'h3);
    mac.recv(1'b1);
    wev(3);
    chk({12'h000, ev}, 16'h0008, 16'h0008);
    wr(0, 16'h0080, 2'h3);
    rd(`OFF_QUEUE_PORTS);
    chk(d, 16'h8000, 16'h8000);
    rd(0);
    chk(d, 16'h0001, 16'h0001);
    repeat (6) @(posedge clk);
    wr(2, 16'h0005, 2'h3);
    wr(0, 16'h0040, 2'h3);
    rd(`OFF_ALLOC_RESULT);
    chk(d, 16'h0080, 16'h0080);
    rd(`OFF_PACKET_SELECT);
    chk(d, 16'h0000, 16'h00FF);
    rd(`OFF_QUEUE_PORTS);
    chk(d, 16'h8080, 16'h8080);
    alloc(6'h00);
    stop_test;
  end
endmodule // tb
